// ### core/bcp_top.sv
// configuration load port: master, peripheral and slave modes with readback
// Functional notes
// - read clock: seven cycles low, one high
// - rate pin stretches clock phases eightfold
// - new address per read clock; capture on rise
// - master parallel bits start 1.5 cycles later
// - async peripheral bits change on falls
// - not ready 1 to 8 cycles per write
// - status read drives only the status line
// - write strobe with selects at least 100 ns
// - sync peripheral byte forwarded 1.5 cycles later
// - slave serial bit passes on next fall
// - slave parallel pins sampled on clock rise
// - slave parallel forwards nothing serially
// - readback follows clock; two high aborts
// - master clock 10 or 1.25 MHz
`timescale 1ns/1ps
`include "bcp_map.svh"
module bcp_top #(
  parameter int AW = 18
) (
  input  wire logic          CLOCK,
  input  wire logic          RST,
  input  wire logic [2:0]    MODE_PINS,
  input  wire logic          RATE_SELECT_PIN,
  input  wire logic          CONFIG_CLOCK_I,
  output logic               CONFIG_CLOCK_O,
  output logic               CONFIG_CLOCK_OE,
  input  wire logic          SERIAL_CONFIG_IN,
  output logic               SERIAL_PASS_OUT,
  input  wire logic [7:0]    CONFIG_BYTE_BUS_I,
  output logic [7:0]         CONFIG_BYTE_BUS_O,
  output logic [7:0]         CONFIG_BYTE_BUS_OE,
  output logic [AW-1:0]      BYTE_ADDR_OUT,
  output logic               READ_CLOCK_OUT,
  input  wire logic          WRITE_STROBE_N,
  input  wire logic          CHIP_SELECT_LOW_N,
  input  wire logic          CHIP_SELECT_HIGH,
  input  wire logic          READ_STATUS_STROBE_N,
  output logic               READY_OUT,
  input  wire logic          READBACK_REQUEST_N,
  input  wire logic          READBACK_DATA_IN,
  output logic               READBACK_OUT,
  output logic               READBACK_ACTIVE,
  output logic               READBACK_NEXT,
  output logic [7:0]         LOAD_BYTE,
  output logic               LOAD_BYTE_VALID
);
  // ==================== pin synchronisers
  bcp_pkg::bcp_pins_t pins_raw;
  bcp_pkg::bcp_pins_t sync1_q;
  bcp_pkg::bcp_pins_t s_q;
  assign pins_raw = '{config_clock: CONFIG_CLOCK_I, din: SERIAL_CONFIG_IN, wr_n: WRITE_STROBE_N,
                      csl_n: CHIP_SELECT_LOW_N, csh: CHIP_SELECT_HIGH,
                      rd_n: READ_STATUS_STROBE_N, rb_req_n: READBACK_REQUEST_N,
                      rate: RATE_SELECT_PIN, mode: MODE_PINS, bus: CONFIG_BYTE_BUS_I};
  always_ff @(posedge CLOCK) begin
    sync1_q <= pins_raw;
    s_q     <= sync1_q;
  end

  bcp_pkg::bcp_mode_t mode;
  assign mode = bcp_pkg::bcp_mode_t'(s_q.mode);
  wire is_ms  = (mode == bcp_pkg::BCP_MASTER_SERIAL);
  wire is_mp  = (mode == bcp_pkg::BCP_MASTER_PARALLEL);
  wire is_ap  = (mode == bcp_pkg::BCP_ASYNC_PERIPH);
  wire is_sp  = (mode == bcp_pkg::BCP_SYNC_PERIPH);
  wire is_ss  = (mode == bcp_pkg::BCP_SLAVE_SERIAL);
  wire is_spl = (mode == bcp_pkg::BCP_SLAVE_PARALLEL);
  wire int_clk = is_ms | is_mp | is_ap;
  wire serial_md = is_ms | is_ss;

  // ==================== config clock: own divider or sampled pin
  localparam logic [3:0] HALF_FAST = 4'(`BCP_HALF_FAST_CYC);
  localparam logic [3:0] HALF_SLOW = 4'(`BCP_HALF_SLOW_CYC);
  logic [3:0] div_q;
  logic       config_clock_q;
  logic       config_clock_prev_q;
  wire [3:0]  half = s_q.rate ? HALF_SLOW : HALF_FAST;
  wire        wrap = (div_q == half - 4'h1);
  wire        g_rise = int_clk & wrap & ~config_clock_q;
  wire        g_fall = int_clk & wrap & config_clock_q;
  wire        e_rise = ~int_clk & s_q.config_clock & ~config_clock_prev_q;
  wire        e_fall = ~int_clk & ~s_q.config_clock & config_clock_prev_q;
  wire        rise = g_rise | e_rise;
  wire        fall = g_fall | e_fall;
  always_ff @(posedge CLOCK) begin
    if (RST | ~int_clk) begin
      div_q  <= 4'h0;
      config_clock_q <= 1'b0;
    end else if (wrap) begin
      div_q  <= 4'h0;
      config_clock_q <= ~config_clock_q;
    end else begin
      div_q  <= div_q + 4'h1;
    end
  end
  always_ff @(posedge CLOCK) begin
    config_clock_prev_q <= RST ? 1'b0 : s_q.config_clock;
  end
  assign CONFIG_CLOCK_O = config_clock_q;
  always_ff @(posedge CLOCK) begin
    CONFIG_CLOCK_OE <= RST ? 1'b0 : int_clk;
  end

  // ==================== master parallel read clock and address
  localparam logic [2:0] RC_LAST = 3'(`BCP_RCLK_LOW_CONFIG_CLOCK + `BCP_RCLK_HIGH_CONFIG_CLOCK - 1);
  logic [2:0]    rc_q;
  logic [AW-1:0] addr_q;
  wire mp_cap = is_mp & rise & (rc_q == RC_LAST - 3'h1);
  always_ff @(posedge CLOCK) begin
    if (RST | ~is_mp) begin
      rc_q <= 3'h0;
    end else if (rise) begin
      rc_q <= (rc_q == RC_LAST) ? 3'h0 : rc_q + 3'h1;
    end
  end
  // address steps at read clock rise
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      addr_q         <= AW'(`BCP_ADDR_RESET);
      READ_CLOCK_OUT <= 1'b0;
    end else begin
      if (mp_cap) addr_q <= addr_q + 1'b1;
      READ_CLOCK_OUT <= is_mp & (rise ? (rc_q == RC_LAST - 3'h1) : (rc_q == RC_LAST));
    end
  end
  assign BYTE_ADDR_OUT = addr_q;

  // ==================== peripheral and slave parallel byte intake
  localparam logic [1:0] WR_MIN = 2'(`BCP_WR_MIN_CYC);
  wire        sel = ~s_q.csl_n & s_q.csh;
  wire        strobe = sel & ~s_q.wr_n;
  logic [1:0] wr_cnt_q;
  logic       strobe_q;
  logic [7:0] ap_data_q;
  wire        hold_v;
  wire        ap_take = is_ap & strobe_q & ~strobe & (wr_cnt_q >= WR_MIN) & ~hold_v;
  // one byte per free clock rise
  wire        sp_take = is_sp & rise & ~hold_v;
  wire        spl_take = is_spl & rise & strobe;
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      wr_cnt_q  <= 2'h0;
      strobe_q  <= 1'b0;
      ap_data_q <= 8'h00;
    end else begin
      strobe_q <= strobe;
      if (!strobe) wr_cnt_q <= 2'h0;
      else if (wr_cnt_q != 2'h3) wr_cnt_q <= wr_cnt_q + 2'h1;
      if (strobe) ap_data_q <= s_q.bus;
    end
  end

  // ==================== serializer for forwarded bytes
  wire       ser_ld = mp_cap | ap_take | sp_take;
  wire [7:0] ser_data = is_ap ? ap_data_q : s_q.bus;
  wire       ser_emit;
  wire       ser_bit;
  // extra half cycle; async starts on next fall
  // flushed outside forwarding modes; a direct switch between two forwarding modes keeps any stale byte
  bcp_serializer #(.W(`BCP_BYTE_W)) u_ser (
    .clk      (CLOCK),
    .rst      (RST | ~(is_mp | is_ap | is_sp)),
    .fall     (fall),
    .ld       (ser_ld),
    .ld_data  (ser_data),
    .ld_skip  (~is_ap),
    .emit     (ser_emit),
    .emit_bit (ser_bit),
    .hold_v   (hold_v)
  );

  // ==================== serial modes and pass output
  logic       din_q;
  logic [7:0] asm_q;
  logic [2:0] asm_cnt_q;
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      din_q           <= 1'b0;
      asm_q           <= 8'h00;
      asm_cnt_q       <= 3'h0;
      SERIAL_PASS_OUT <= 1'b0;
      LOAD_BYTE       <= 8'h00;
      LOAD_BYTE_VALID <= 1'b0;
    end else begin
      LOAD_BYTE_VALID <= 1'b0;
      if (serial_md & rise) begin
        din_q     <= s_q.din;
        asm_q     <= {asm_q[6:0], s_q.din};
        asm_cnt_q <= asm_cnt_q + 3'h1;
        if (asm_cnt_q == 3'h7) begin
          LOAD_BYTE       <= {asm_q[6:0], s_q.din};
          LOAD_BYTE_VALID <= 1'b1;
        end
      end else if (ser_ld | spl_take) begin
        LOAD_BYTE       <= ser_ld ? ser_data : s_q.bus;
        LOAD_BYTE_VALID <= 1'b1;
      end
      if (is_spl) SERIAL_PASS_OUT <= 1'b0;
      // bit passes on the next fall
      else if (serial_md & fall) SERIAL_PASS_OUT <= din_q;
      else if (ser_emit) SERIAL_PASS_OUT <= ser_bit;
    end
  end

  // ==================== ready pin and status read
  // low until holding register drains
  // writes while not ready are dropped
  wire rd_act = is_ap & sel & ~s_q.rd_n;
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      READY_OUT          <= 1'b1;
      CONFIG_BYTE_BUS_O  <= 8'h00;
      CONFIG_BYTE_BUS_OE <= 8'h00;
    end else begin
      READY_OUT <= ~(hold_v | ser_ld);
      // only the status line is driven
      CONFIG_BYTE_BUS_O  <= {~(hold_v | ser_ld), 7'h00};
      CONFIG_BYTE_BUS_OE <= {rd_act, 7'h00};
    end
  end

  // ==================== readback
  // request is sampled only at clock rise
  bcp_pkg::bcp_rb_state_t rb_q;
  logic [1:0] rb_hi_q;
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      rb_q    <= bcp_pkg::BCP_RB_IDLE;
      rb_hi_q <= 2'h0;
    end else if (rise) begin
      case (rb_q)
        bcp_pkg::BCP_RB_IDLE: begin
          rb_hi_q <= 2'h0;
          if (!s_q.rb_req_n) rb_q <= bcp_pkg::BCP_RB_ACTIVE;
        end
        bcp_pkg::BCP_RB_ACTIVE: begin
          if (!s_q.rb_req_n) rb_hi_q <= 2'h0;
          else if (rb_hi_q == 2'(`BCP_RB_ABORT_CONFIG_CLOCK - 1)) rb_q <= bcp_pkg::BCP_RB_IDLE;
          else rb_hi_q <= rb_hi_q + 2'h1;
        end
        default: rb_q <= bcp_pkg::BCP_RB_IDLE;
      endcase
    end
  end
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      READBACK_OUT  <= 1'b0;
      READBACK_NEXT <= 1'b0;
    end else begin
      READBACK_NEXT <= fall & (rb_q == bcp_pkg::BCP_RB_ACTIVE);
      if (fall & (rb_q == bcp_pkg::BCP_RB_ACTIVE)) READBACK_OUT <= READBACK_DATA_IN;
    end
  end
  always_ff @(posedge CLOCK) begin
    READBACK_ACTIVE <= RST ? 1'b0 : (rb_q == bcp_pkg::BCP_RB_ACTIVE);
  end

  // ==================== checks
  // window of steady slow rate; a rate change or a mode without the own divider ends the check
  sequence slow_high_s;
    (int_clk & s_q.rate) [*7];
  endsequence
  clk_slow_a: assert property (@(posedge CLOCK) disable iff (RST)
    int_clk & s_q.rate & $rose(CONFIG_CLOCK_O) ##1 slow_high_s
      |-> CONFIG_CLOCK_O ##1 ~CONFIG_CLOCK_O)
    else $error("slow master clock phase not eight cycles");
  clk_fast_a: assert property (@(posedge CLOCK) disable iff (RST)
    int_clk & ~s_q.rate & $stable(s_q.rate) & $rose(CONFIG_CLOCK_O) |=> ~CONFIG_CLOCK_O)
    else $error("fast master clock phase not one cycle");
  rclk_high_a: assert property (@(posedge CLOCK) disable iff (RST)
    $rose(READ_CLOCK_OUT) |-> $past(rc_q) == RC_LAST - 3'h1)
    else $error("read clock rose at wrong count");
  addr_step_a: assert property (@(posedge CLOCK) disable iff (RST)
    mp_cap |=> BYTE_ADDR_OUT == $past(BYTE_ADDR_OUT) + 1'b1)
    else $error("address did not step on read clock rise");
  ready_low_a: assert property (@(posedge CLOCK) disable iff (RST)
    ap_take |=> ~READY_OUT ##[1:128] READY_OUT)
    else $error("ready not restored in time");
  status_only_a: assert property (@(posedge CLOCK) disable iff (RST)
    CONFIG_BYTE_BUS_OE[6:0] == 7'h00 && (CONFIG_BYTE_BUS_OE[7] -> $past(rd_act)))
    else $error("byte bus driven outside status line");
  short_wr_a: assert property (@(posedge CLOCK) disable iff (RST)
    is_ap & $fell(strobe) & wr_cnt_q < WR_MIN |-> ~ap_take)
    else $error("short write strobe accepted");
  pass_bit_a: assert property (@(posedge CLOCK) disable iff (RST)
    serial_md & fall & ~is_spl |=> SERIAL_PASS_OUT == $past(din_q))
    else $error("serial bit not passed on fall");
  no_chain_a: assert property (@(posedge CLOCK) disable iff (RST)
    is_spl |=> ~SERIAL_PASS_OUT)
    else $error("slave parallel forwarded data");
  rb_abort_a: assert property (@(posedge CLOCK) disable iff (RST)
    rise & (rb_q == bcp_pkg::BCP_RB_ACTIVE) & s_q.rb_req_n & (rb_hi_q == 2'h1)
      |=> rb_q == bcp_pkg::BCP_RB_IDLE)
    else $error("readback not aborted");
endmodule

// ### core/bcp_map.svh
// constants of the bitstream configuration port: timing counts and field positions
`ifndef BCP_MAP_SVH
`define BCP_MAP_SVH
// ==================== clock and rate
`define BCP_SYS_PERIOD_NS    50
`define BCP_MS_FAST_PER_NS   100
`define BCP_RATE_FACTOR      8
`define BCP_HALF_FAST_CYC    (`BCP_MS_FAST_PER_NS / (2 * `BCP_SYS_PERIOD_NS))
`define BCP_HALF_SLOW_CYC    (`BCP_HALF_FAST_CYC * `BCP_RATE_FACTOR)
// ==================== master parallel read clock, in config clock cycles
`define BCP_RCLK_LOW_CONFIG_CLOCK    7
`define BCP_RCLK_HIGH_CONFIG_CLOCK   1
// ==================== peripheral strobes and readback
`define BCP_WR_MIN_NS        100
`define BCP_WR_MIN_CYC       ((`BCP_WR_MIN_NS + `BCP_SYS_PERIOD_NS - 1) / `BCP_SYS_PERIOD_NS)
`define BCP_RB_ABORT_CONFIG_CLOCK    2
// ==================== byte bus fields and reset values
`define BCP_STATUS_BIT       7
`define BCP_ADDR_RESET       18'h00000
`define BCP_BYTE_W           8
`endif

// ### core/bcp_pkg.sv
// types of the bitstream configuration port
package bcp_pkg;
  typedef enum logic [2:0] {
    BCP_MASTER_SERIAL   = 3'h0,
    BCP_MASTER_PARALLEL = 3'h1,
    BCP_ASYNC_PERIPH    = 3'h2,
    BCP_SYNC_PERIPH     = 3'h3,
    BCP_SLAVE_SERIAL    = 3'h4,
    BCP_SLAVE_PARALLEL  = 3'h5,
    BCP_IDLE_A          = 3'h6,
    BCP_IDLE_B          = 3'h7
  } bcp_mode_t;

  typedef enum logic [1:0] {
    BCP_RB_IDLE   = 2'b00,
    BCP_RB_ACTIVE = 2'b01
  } bcp_rb_state_t;

  typedef struct packed {
    logic       config_clock;
    logic       din;
    logic       wr_n;
    logic       csl_n;
    logic       csh;
    logic       rd_n;
    logic       rb_req_n;
    logic       rate;
    logic [2:0] mode;
    logic [7:0] bus;
  } bcp_pins_t;
endpackage

// ### core/bcp_serializer.sv
// byte to bit serializer with one holding register, bits leave on config clock falls
`timescale 1ns/1ps
module bcp_serializer #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         fall,
  input  wire logic         ld,
  input  wire logic [W-1:0] ld_data,
  input  wire logic         ld_skip,
  output logic              emit,
  output logic              emit_bit,
  output logic              hold_v
);
  localparam int CW = $clog2(W + 1);
  logic [W-1:0]  hold_q;
  logic          hold_v_q;
  logic          skip_q;
  logic [W-1:0]  sh_q;
  logic [CW-1:0] cnt_q;
  wire           busy = (cnt_q != '0);
  // ==================== emit control
  // skip marks the first fall after a load, giving the extra half cycle
  wire           move = fall & ~busy & hold_v_q & ~skip_q;
  assign emit     = fall & (busy | move);
  // fixed order: most significant bit first
  assign emit_bit = busy ? sh_q[W-1] : hold_q[W-1];
  assign hold_v   = hold_v_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      hold_q   <= '0;
      hold_v_q <= 1'b0;
      skip_q   <= 1'b0;
    end else if (ld) begin
      hold_q   <= ld_data;
      hold_v_q <= 1'b1;
      skip_q   <= ld_skip;
    end else begin
      if (move) hold_v_q <= 1'b0;
      if (fall) skip_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sh_q  <= '0;
      cnt_q <= '0;
    end else if (move) begin
      sh_q  <= {hold_q[W-2:0], 1'b0};
      cnt_q <= CW'(W - 1);
    end else if (emit) begin
      sh_q  <= {sh_q[W-2:0], 1'b0};
      cnt_q <= cnt_q - 1'b1;
    end
  end

  // ==================== checks
  // half cycle skip
  skip_first_a: assert property (@(posedge clk) disable iff (rst)
    fall & skip_q & ~busy |-> ~emit)
    else $error("bit emitted on the skipped fall");
  eight_bits_a: assert property (@(posedge clk) disable iff (rst)
    move |=> cnt_q == CW'(W - 1))
    else $error("serializer count wrong after move");
endmodule

// ### testbench/bcp_far_model.sv
// far side of the port: byte-wide memory and external configuration clock
`timescale 1ns/1ps
module bcp_far_model (
  input  wire logic        clk_run,
  input  wire logic [17:0] addr,
  output logic             ext_config_clock,
  output logic [7:0]       mem_byte
);
  // ==================== memory
  // addressed byte returned
  assign #30 mem_byte = addr[7:0] ^ 8'hA5;
  // ==================== link clock
  // slow clock, stands low
  initial begin
    ext_config_clock = 1'b0;
    #7;
    forever begin
      wait (clk_run);
      #200 ext_config_clock = 1'b1;
      #200 ext_config_clock = 1'b0;
    end
  end
endmodule

// ### testbench/bcp_top_tb_top.sv
// self-checking bench of the configuration load port
`timescale 1ns/1ps
`include "bcp_map.svh"
module bcp_top_tb_top;
  // ==================== signals
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [2:0]  mode = 3'h6;
  logic        rate = 1'b0, din = 1'b0, run = 1'b0;
  logic        wr_n = 1'b1, csl_n = 1'b1, csh = 1'b0, rd_n = 1'b1;
  logic        rbq_n = 1'b1, rb_data = 1'b0, prev_o = 1'b0;
  logic [7:0]  tb_bus = 8'h00;
  logic        ext_config_clock, config_clock_o, spo, rclk, rdy, rb_out, rb_act, lb_v;
  logic [7:0]  mem_byte, bus_i, bus_o, bus_oe, lb;
  logic [17:0] addr;
  int          errors = 0;
  int          num_checks = 0;
  always #25 clk = ~clk;
  always @(posedge clk) prev_o <= config_clock_o;
  // memory owns the bus only in master parallel mode
  assign bus_i = (mode == 3'h1) ? mem_byte : tb_bus;
  bcp_far_model bcp_far_model_i (.clk_run(run), .addr(addr), .ext_config_clock(ext_config_clock),
    .mem_byte(mem_byte));
  bcp_top bcp_top_i (
    .CLOCK(clk), .RST(rst), .MODE_PINS(mode), .RATE_SELECT_PIN(rate),
    .CONFIG_CLOCK_I(ext_config_clock), .CONFIG_CLOCK_O(config_clock_o), .CONFIG_CLOCK_OE(),
    .SERIAL_CONFIG_IN(din), .SERIAL_PASS_OUT(spo), .CONFIG_BYTE_BUS_I(bus_i),
    .CONFIG_BYTE_BUS_O(bus_o), .CONFIG_BYTE_BUS_OE(bus_oe), .BYTE_ADDR_OUT(addr),
    .READ_CLOCK_OUT(rclk), .WRITE_STROBE_N(wr_n), .CHIP_SELECT_LOW_N(csl_n),
    .CHIP_SELECT_HIGH(csh), .READ_STATUS_STROBE_N(rd_n), .READY_OUT(rdy),
    .READBACK_REQUEST_N(rbq_n), .READBACK_DATA_IN(rb_data), .READBACK_OUT(rb_out),
    .READBACK_ACTIVE(rb_act), .READBACK_NEXT(), .LOAD_BYTE(lb), .LOAD_BYTE_VALID(lb_v));
  // ==================== helpers
  task automatic chk1(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: bit %b expected %b", $time, got, exp);
    end
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: byte %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkn(input int got, input int exp);
    num_checks++;
    if (got != exp) begin
      errors++;
      $display("mismatch at %0t: count %0d expected %0d", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wait_for(ref logic s, input logic v, input int lim, output int n);
    n = 0;
    while (s !== v && n < lim) begin
      tick(1);
      n++;
    end
    if (n == lim) begin
      errors++;
      $display("mismatch at %0t: wait ran out", $time);
    end
  endtask
  task automatic xf();
    @(negedge ext_config_clock);
    tick(1);
  endtask
  task automatic xr();
    @(posedge ext_config_clock);
    tick(5);
  endtask
  // strobe held whole cycles; ready is not checked before the write
  task automatic host_wr(input logic [7:0] b, input int cyc);
    tb_bus = b;
    wr_n = 1'b0;
    csl_n = 1'b0;
    csh = 1'b1;
    tick(cyc);
    wr_n = 1'b1;
    csl_n = 1'b1;
    csh = 1'b0;
  endtask
  task automatic get_bits(output logic [7:0] b);
    int k;
    // a fall on the accept edge cannot carry the new byte
    tick(1);
    for (int i = 0; i < 8; i++) begin
      k = 0;
      while (!(prev_o === 1'b1 && config_clock_o === 1'b0) && k < 40) begin
        tick(1);
        k++;
      end
      tick(1);
      b[7 - i] = spo;
      if (i == 0) begin
        tick(1);
        chk1(rdy, 1'b1);
      end
    end
  endtask
  // ==================== scenarios
  task automatic t_sserial(input logic [7:0] v);
    int n;
    mode = 3'h4;
    tick(4);
    for (int i = 0; i < 9; i++) begin
      if (i > 0) xf();
      din = (i < 8) ? v[7 - i] : 1'b0;
      run = 1'b1;
      @(posedge ext_config_clock);
      #1;
      if (i > 0) chk1(spo, v[8 - i]);
      if (i == 7) begin
        wait_for(lb_v, 1'b1, 10, n);
        chk8(lb, v);
      end
    end
  endtask
  task automatic t_rdback();
    xf();
    rb_data = 1'b1;
    rbq_n = 1'b0;
    xr();
    chk1(rb_act, 1'b1);
    xf();
    tick(4);
    chk1(rb_out, 1'b1);
    rb_data = 1'b0;
    xf();
    tick(4);
    chk1(rb_out, 1'b0);
    rbq_n = 1'b1;
    xr();
    xf();
    rbq_n = 1'b0;
    xr();
    chk1(rb_act, 1'b1);
    xf();
    rbq_n = 1'b1;
    xr();
    xr();
    chk1(rb_act, 1'b0);
    run = 1'b0;
  endtask
  task automatic t_spar();
    int n;
    mode = 3'h5;
    tick(4);
    run = 1'b1;
    xf();
    tb_bus = 8'h3C;
    wr_n = 1'b0;
    csl_n = 1'b0;
    csh = 1'b1;
    @(posedge ext_config_clock);
    wait_for(lb_v, 1'b1, 10, n);
    chk8(lb, 8'h3C);
    xf();
    wr_n = 1'b1;
    csl_n = 1'b1;
    csh = 1'b0;
    for (int i = 0; i < 20; i++) begin
      tick(1);
      chk1(spo, 1'b0);
    end
    run = 1'b0;
  endtask
  task automatic t_syncp(input logic [7:0] v);
    int n;
    logic [7:0] b;
    tick(20);
    mode = 3'h3;
    tb_bus = v;
    tick(4);
    run = 1'b1;
    @(posedge ext_config_clock);
    wait_for(lb_v, 1'b1, 10, n);
    chk8(lb, v);
    xf();
    tick(3);
    chk1(spo, 1'b0);
    for (int i = 0; i < 8; i++) begin
      xf();
      tick(3);
      b[7 - i] = spo;
    end
    chk8(b, v);
    run = 1'b0;
    mode = 3'h6;
    tick(20);
  endtask
  task automatic t_mserial();
    int n;
    din = 1'b1;
    rate = 1'b0;
    mode = 3'h0;
    wait_for(lb_v, 1'b1, 40, n);
    tick(1);
    wait_for(lb_v, 1'b1, 40, n);
    chk8(lb, 8'hFF);
    tick(4);
    chk1(spo, 1'b1);
    din = 1'b0;
    mode = 3'h6;
    tick(4);
  endtask
  task automatic t_async();
    int n;
    logic [7:0] b;
    rate = 1'b1;
    mode = 3'h2;
    tick(4);
    b = lb;
    host_wr(8'h5A, 1);
    tick(8);
    chk1(lb_v, 1'b0);
    chk8(lb, b);
    host_wr(8'hB4, `BCP_WR_MIN_CYC + 1);
    wait_for(lb_v, 1'b1, 10, n);
    chk8(lb, 8'hB4);
    chk1(rdy, 1'b0);
    get_bits(b);
    chk8(b, 8'hB4);
    tick(40);
    rd_n = 1'b0;
    csl_n = 1'b0;
    csh = 1'b1;
    tick(3);
    chk8(bus_oe, 8'h80);
    chk8(bus_o, 8'h80);
    rd_n = 1'b1;
    csh = 1'b0;
    csl_n = 1'b1;
    tick(3);
    chk8(bus_oe, 8'h00);
    host_wr(8'h4D, `BCP_WR_MIN_CYC + 1);
    wait_for(lb_v, 1'b1, 10, n);
    chk8(lb, 8'h4D);
    tick(160);
  endtask
  task automatic t_mpar(input logic r);
    int n;
    int per;
    per = 2 * `BCP_HALF_FAST_CYC * (r ? `BCP_RATE_FACTOR : 1);
    rate = r;
    mode = 3'h1;
    wait_for(config_clock_o, 1'b1, 600, n);
    wait_for(config_clock_o, 1'b0, 600, n);
    chkn(n, per / 2);
    wait_for(rclk, 1'b1, 600, n);
    wait_for(rclk, 1'b0, 600, n);
    wait_for(rclk, 1'b1, 600, n);
    chkn(n, `BCP_RCLK_LOW_CONFIG_CLOCK * per);
    chk8(lb, (addr[7:0] - 8'h01) ^ 8'hA5);
    wait_for(rclk, 1'b0, 600, n);
    chkn(n, `BCP_RCLK_HIGH_CONFIG_CLOCK * per);
    mode = 3'h6;
    tick(4);
  endtask
  // ==================== run
  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    tick(20);
    chk1(rdy, 1'b1);
    chk8(bus_oe, 8'h00);
    chk1(rclk, 1'b0);
    rst = 1'b0;
    tick(4);
    t_sserial(8'hC5);
    t_rdback();
    t_spar();
    t_syncp(8'hA6);
    t_async();
    t_mpar(1'b0);
    t_mpar(1'b1);
    t_mserial();
    final_report();
  end
  // longest scenario needs well under a millisecond
  initial begin
    #3000000;
    errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    final_report();
  end
endmodule
